/* gwst_consts.vh */
// Constants for the general window space/type select register bank.
// Assumes inclusion by bare name from the design files.
`ifndef GWST_CONSTS_VH
`define GWST_CONSTS_VH
`define GWST_OFS_HOST_SPACE 12'h0922
`define GWST_OFS_CARD_SPACE 12'h0923
`define GWST_OFS_MODE_SEL 12'h0924
`define GWST_RST_HOST_SPACE 8'hC0
`define GWST_RST_CARD_SPACE 8'hC0
`define GWST_RST_MODE_SEL 8'h00
`define GWST_RSVD_MASK 8'hDF
`define GWST_RSVD_BIT 5
`define GWST_NUM_WIN 7
`define GWST_ADDR_W 12
`define GWST_SOCK_W 1
`endif

/* gwst_win_map.v */
// Per-window decode mapping for the general window space/type select.
// Assumes the three type bytes come from the register bank.
`include "gwst_consts.vh"
module gwst_win_map (
    input wire [7:0] host_space_i,
    input wire [7:0] card_space_i,
    input wire [7:0] mode_sel_i,
    output wire [6:0] prog_en_o,
    output wire [6:0] host_mem_o,
    output wire [6:0] host_io_o,
    output wire [6:0] card_mem_o,
    output wire [6:0] card_io_o
);
    // Collapse register bits 7:6,4:0 to window index 6:0
    function [6:0] gwst_pack;
        input [7:0] b;
        begin
            gwst_pack = {b[7:6], b[4:0]}; // RL1
        end
    endfunction

    wire [6:0] hs;
    wire [6:0] cs;
    assign hs = gwst_pack(host_space_i);
    assign cs = gwst_pack(card_space_i);
    assign prog_en_o = gwst_pack(mode_sel_i); // RL7
    // Default-mode windows ignore both space bits
    assign host_mem_o = prog_en_o & ~hs; // RL2 RL4
    assign host_io_o = prog_en_o & hs; // RL3 RL4
    assign card_mem_o = prog_en_o & ~cs; // RL5 RL4
    assign card_io_o = prog_en_o & cs; // RL6 RL4
endmodule // gwst_win_map

/* gwst_regs.v */
// Register bank holding per-socket window space and type selections.
// Assumes a synchronous byte-wide register access port on the host clock.
`include "gwst_consts.vh"
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// [RL1] Windows 0-4 sit on bits 0-4, windows 5-6 on bits 6-7, bit 5 reserved.
// [RL2] A programmable window with host-space bit 0 decodes memory cycles.
// [RL3] A programmable window with host-space bit 1 decodes I/O cycles.
// [RL4] A default-mode window ignores its host-space and card-space bits.
// [RL5] A programmable window with card-space bit 0 issues card memory cmds.
// [RL6] A programmable window with card-space bit 1 issues card I/O cmds.
// [RL7] Mode bit set means programmable; clear means legacy default setup.
// [RL8] Each socket has its own copy, picked by the socket index on access.
module gwst_regs #(
    parameter NUM_SOCK = 2,
    parameter SOCK_W = `GWST_SOCK_W
) (
    input wire sys_clk_i,
    input wire arst_n_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [`GWST_ADDR_W-1:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire [SOCK_W-1:0] reg_sock_i,
    input wire [SOCK_W-1:0] dec_sock_i,
    output reg [7:0] reg_rdata_o,
    output wire reg_hit_o,
    output wire [6:0] prog_en_o,
    output wire [6:0] host_mem_o,
    output wire [6:0] host_io_o,
    output wire [6:0] card_mem_o,
    output wire [6:0] card_io_o
);

    //////////////////////////////////////////////////////////////////////////
    // Storage, one copy of each type byte per socket
    reg [7:0] host_space_reg [0:NUM_SOCK-1];
    reg [7:0] card_space_reg [0:NUM_SOCK-1];
    reg [7:0] mode_sel_reg [0:NUM_SOCK-1];

    // Next values of the storage
    reg [7:0] host_space_next [0:NUM_SOCK-1];
    reg [7:0] card_space_next [0:NUM_SOCK-1];
    reg [7:0] mode_sel_next [0:NUM_SOCK-1];

    // Next value of the read data holding register
    reg [7:0] rdata_next;

    // Address decode
    wire hit_host;
    wire hit_card;
    wire hit_mode;

    // Qualified strobes
    wire wr_host;
    wire wr_card;
    wire wr_mode;
    wire rd_host;
    wire rd_card;
    wire rd_mode;

    // Type bytes of the socket being decoded
    wire [7:0] dec_host_space;
    wire [7:0] dec_card_space;
    wire [7:0] dec_mode_sel;

    integer i;
    integer j;

    //////////////////////////////////////////////////////////////////////////
    // Helpers

    // True when the access address names the given register
    function gwst_hit;
        input [`GWST_ADDR_W-1:0] addr;
        input [`GWST_ADDR_W-1:0] ofs;
        begin
            gwst_hit = (addr == ofs);
        end
    endfunction

    // Reserved bit is never stored, so it always reads back 0
    function [7:0] gwst_clean;
        input [7:0] b;
        begin
            gwst_clean = b & `GWST_RSVD_MASK; // RL1
        end
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Register access decode

    assign hit_host = gwst_hit(reg_addr_i, `GWST_OFS_HOST_SPACE);
    assign hit_card = gwst_hit(reg_addr_i, `GWST_OFS_CARD_SPACE);
    assign hit_mode = gwst_hit(reg_addr_i, `GWST_OFS_MODE_SEL);
    assign reg_hit_o = hit_host | hit_card | hit_mode;

    assign wr_host = reg_wr_i & hit_host;
    assign wr_card = reg_wr_i & hit_card;
    assign wr_mode = reg_wr_i & hit_mode;
    assign rd_host = reg_rd_i & hit_host;
    assign rd_card = reg_rd_i & hit_card;
    assign rd_mode = reg_rd_i & hit_mode;

    //////////////////////////////////////////////////////////////////////////
    // Next storage values: writes land only in the addressed socket's copy

    always @* begin
        for (j = 0; j < NUM_SOCK; j = j + 1) begin
            host_space_next[j] = host_space_reg[j];
            card_space_next[j] = card_space_reg[j];
            mode_sel_next[j] = mode_sel_reg[j];
        end
        if (wr_host) begin
            host_space_next[reg_sock_i] = gwst_clean(reg_wdata_i); // RL8
        end
        if (wr_card) begin
            card_space_next[reg_sock_i] = gwst_clean(reg_wdata_i); // RL8
        end
        if (wr_mode) begin
            mode_sel_next[reg_sock_i] = gwst_clean(reg_wdata_i); // RL8
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Storage flip-flops

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (i = 0; i < NUM_SOCK; i = i + 1) begin
                host_space_reg[i] <= `GWST_RST_HOST_SPACE;
                card_space_reg[i] <= `GWST_RST_CARD_SPACE;
                mode_sel_reg[i] <= `GWST_RST_MODE_SEL;
            end
        end else begin
            for (i = 0; i < NUM_SOCK; i = i + 1) begin
                host_space_reg[i] <= host_space_next[i];
                card_space_reg[i] <= card_space_next[i];
                mode_sel_reg[i] <= mode_sel_next[i];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Read data: loaded on every read strobe, held otherwise
    // A read in the cycle of a write returns the old value

    always @* begin
        rdata_next = reg_rdata_o;
        if (rd_host) begin
            rdata_next = host_space_reg[reg_sock_i]; // RL8
        end else if (rd_card) begin
            rdata_next = card_space_reg[reg_sock_i]; // RL8
        end else if (rd_mode) begin
            rdata_next = mode_sel_reg[reg_sock_i]; // RL8
        end else if (reg_rd_i) begin
            rdata_next = 8'h00;
        end
    end

    always @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= rdata_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Window decode for the socket the datapath is serving

    assign dec_host_space = host_space_reg[dec_sock_i];
    assign dec_card_space = card_space_reg[dec_sock_i];
    assign dec_mode_sel = mode_sel_reg[dec_sock_i];

    gwst_win_map u_map (
        .host_space_i(dec_host_space),
        .card_space_i(dec_card_space),
        .mode_sel_i(dec_mode_sel),
        .prog_en_o(prog_en_o),
        .host_mem_o(host_mem_o),
        .host_io_o(host_io_o),
        .card_mem_o(card_mem_o),
        .card_io_o(card_io_o)
    );
endmodule // gwst_regs

/* gwst_regs_properties.sv */
// Checker for the window space/type register bank.
// Assumes binding to gwst_regs with one clock and async reset.
module gwst_regs_chk (
    input wire sys_clk_i, arst_n_i, reg_wr_i, reg_rd_i, reg_sock_i,
    input wire dec_sock_i,
    input wire [11:0] reg_addr_i,
    input wire [7:0] reg_wdata_i, reg_rdata_o,
    input wire [6:0] prog_en_o, host_mem_o, host_io_o, card_mem_o, card_io_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    wire wr_on = reg_wr_i && reg_sock_i == dec_sock_i;
    wire [6:0] wm = {reg_wdata_i[7:6], reg_wdata_i[4:0]};
    host_split_a: assert property ((host_mem_o | host_io_o) == prog_en_o
        && !(host_mem_o & host_io_o)) else $error("host split wrong");
    card_split_a: assert property ((card_mem_o | card_io_o) == prog_en_o
        && !(card_mem_o & card_io_o)) else $error("card split wrong");
    dflt_off_a: assert property (((host_io_o | card_io_o) & ~prog_en_o) == 0)
        else $error("default window decodes");
    mode_wr_a: assert property (wr_on && reg_addr_i == 12'h0924 |=>
        !$stable(dec_sock_i) || prog_en_o == $past(wm)) else $error("mode");
    host_wr_a: assert property (wr_on && reg_addr_i == 12'h0922 |=>
        !$stable(dec_sock_i) || host_io_o == (prog_en_o & $past(wm)))
        else $error("host space write");
    card_wr_a: assert property (wr_on && reg_addr_i == 12'h0923 |=>
        !$stable(dec_sock_i) || card_io_o == (prog_en_o & $past(wm)))
        else $error("card space write");
    rd_bit5_a: assert property (reg_rd_i |=> !reg_rdata_o[5])
        else $error("reserved bit reads set");
    sock_iso_a: assert property (reg_wr_i && reg_sock_i != dec_sock_i |=>
        !$stable(dec_sock_i) || $stable({prog_en_o, host_io_o, card_io_o}))
        else $error("other socket changed");
    cover property (wr_on && reg_addr_i == 12'h0924);
    cover property (reg_rd_i && reg_addr_i == 12'h0923);
    cover property (reg_wr_i && reg_sock_i != dec_sock_i);
endmodule // gwst_regs_chk

/* gwst_regs_tb_top.sv */
// Random self-checking bench for the window space/type register bank.
// Assumes gwst_regs and its checker are compiled first.
module gwst_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 0, arst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
    logic reg_sock_i = 0, dec_sock_i = 0;
    logic [11:0] reg_addr_i = 0;
    logic [7:0] reg_wdata_i = 0, reg_rdata_o, exp_rd = 0;
    logic [6:0] prog_en_o, host_mem_o, host_io_o, card_mem_o, card_io_o;
    logic [6:0] p, h, c;
    logic hx;
    logic [7:0] m [2][3] = '{'{8'hC0, 8'hC0, 8'h00}, '{8'hC0, 8'hC0, 8'h00}};
    int miscompares = 0, check_count = 0, a;
    always #5 sys_clk_i = ~sys_clk_i;
    logic reg_hit_o;
    gwst_regs u_dut (.*);
    function automatic logic [6:0] mp(logic [7:0] b);
        return {b[7:6], b[4:0]};
    endfunction
    task automatic chk(logic [42:0] g, logic [42:0] e);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic finish_test;
        if (miscompares == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32854));
        repeat (12) @(posedge sys_clk_i);
        arst_n_i <= 1;
        repeat (800) begin
            @(posedge sys_clk_i);
            a = int'(reg_addr_i) - 'h922;
            if (reg_rd_i) exp_rd = a inside {[0:2]} ? m[reg_sock_i][a] : 8'h00;
            if (reg_wr_i && a inside {[0:2]}) m[reg_sock_i][a] = reg_wdata_i & 8'hDF;
            reg_wr_i <= 1'($urandom);
            reg_rd_i <= 1'($urandom);
            reg_sock_i <= 1'($urandom);
            dec_sock_i <= 1'($urandom);
            reg_addr_i <= 12'h0921 + 12'($urandom % 5);
            reg_wdata_i <= 8'($urandom);
            @(negedge sys_clk_i);
            p = mp(m[dec_sock_i][2]);
            h = mp(m[dec_sock_i][0]);
            c = mp(m[dec_sock_i][1]);
            hx = reg_addr_i >= 12'h0922 && reg_addr_i <= 12'h0924;
            chk({reg_rdata_o, reg_hit_o}, {exp_rd, hx});
            chk({prog_en_o, host_mem_o, host_io_o, card_mem_o, card_io_o},
                {p, p & ~h, p & h, p & ~c, p & c});
        end
        finish_test();
    end
endmodule // gwst_regs_tb_top
bind gwst_regs gwst_regs_chk u_chk (.*);
